//--- design/gpx_pkg.sv
// Shared constants and types for the eight-bit I/O expander
package gpx_pkg;

  // ----------------------------------------------------------------
  // Register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_INPUT_LEVELS    = 8'h00;
  localparam logic [7:0] REG_OUTPUT_LATCH    = 8'h01;
  localparam logic [7:0] REG_POLARITY_INVERT = 8'h02;
  localparam logic [7:0] REG_PIN_DIRECTION   = 8'h03;

  // ----------------------------------------------------------------
  // Reset values and unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT_LATCH_RST    = 8'hff;
  localparam logic [7:0] POLARITY_INVERT_RST = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_RST   = 8'hff;
  localparam logic [7:0] POINTER_RST         = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // ----------------------------------------------------------------
  // Bus address and bit counts
  // ----------------------------------------------------------------
  // Fixed upper address bits, plain default
  localparam logic [4:0] ADDR_FIXED_HIGH     = 5'h0e;
  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
  localparam logic [3:0] LAST_TX_BIT         = 4'h7;

  // ----------------------------------------------------------------
  // Synchroniser bundle: {reset pin, scl, sda, a1, a0, port pins}
  // ----------------------------------------------------------------
  localparam int          SYNC_W   = 13;
  localparam logic [12:0] SYNC_RST = 13'h0c00;

  // ----------------------------------------------------------------
  // Bus target state machine
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_RX   = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } gpx_fsm_type;

  typedef struct packed {
    gpx_fsm_type fsm;
    logic        scl_prev;
    logic        sda_prev;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        rw;
    logic        addr_phase;
    logic        first_byte;
    logic        mnack;
    logic [7:0]  ptr;
    logic [7:0]  latch;
    logic [7:0]  invert;
    logic [7:0]  dir;
    logic [7:0]  ref_lvl;
    logic        ref_ok;
    logic [7:0]  pins_out;
    logic [7:0]  pins_oe;
    logic        int_oe;
    logic        sda_oe;
    logic        drv_low;
  } gpx_state_type;

  localparam gpx_state_type STATE_RST = '{
    fsm:        ST_IDLE,
    scl_prev:   1'b1,
    sda_prev:   1'b1,
    bit_cnt:    4'h0,
    shreg:      8'h00,
    rw:         1'b0,
    addr_phase: 1'b0,
    first_byte: 1'b0,
    mnack:      1'b0,
    ptr:        POINTER_RST,
    latch:      OUTPUT_LATCH_RST,
    invert:     POLARITY_INVERT_RST,
    dir:        PIN_DIRECTION_RST,
    ref_lvl:    8'h00,
    ref_ok:     1'b0,
    pins_out:   OUTPUT_LATCH_RST,
    pins_oe:    8'h00,
    int_oe:     1'b0,
    sda_oe:     1'b0,
    drv_low:    1'b0
  };

endpackage

//--- design/gpx_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module gpx_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [1:0][W-1:0] stg_q;
  logic [1:0][W-1:0] stg_d;

  always_comb begin
    stg_d[0] = d;
    stg_d[1] = stg_q[0];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stg_q <= {RST_VAL, RST_VAL};
    end else begin
      stg_q <= stg_d;
    end
  end

  assign q = stg_q[1];

endmodule

//--- design/gpx_expander.sv
// Eight-bit I/O expander with two-wire bus target and change interrupt
// Overview of operation
// - First byte after address is the pointer
// - Pointer 0..3 selects input, latch, invert, direction
// - Input register reads every pin level
// - Writes to input register are ignored
// - Latch reads return stored value, not pins
// - Latch resets to ones, drives output pins
// - Latch has no effect on input pins
// - Invert bit flips reported input; resets zero
// - Direction 0 drives pin, 1 floats it
// - All pins start as inputs after reset
// - Power-on reset initialises registers and machine
// - Reset pin low holds everything at defaults
// - Input pin change asserts interrupt
// - Interrupt clears on return or input read
// - Output-to-input switch may raise interrupt
// - Input pins have both drivers off
// - Output pins enable exactly one driver
// - Pointer never auto-increments
// - Interrupt output is active low
// - Reset pin is active low
// - Two select pins set address low bits
`timescale 1ns/1ps
module gpx_expander (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reset_pin_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_select_pin0,
  input  wire logic       addr_select_pin1,
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_pins_oe,
  output logic            int_n_out,
  output logic            int_n_oe
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [gpx_pkg::SYNC_W-1:0] sync_q;
  logic                       rstn_s;
  logic                       scl_s;
  logic                       sda_s;
  logic [1:0]                 asel_s;
  logic [7:0]                 pins_s;
  logic                       int_rst;

  gpx_sync #(
    .W       (gpx_pkg::SYNC_W),
    .RST_VAL (gpx_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({reset_pin_n, scl, sda_in, addr_select_pin1, addr_select_pin0, port_pins_in}),
    .q       (sync_q)
  );

  assign {rstn_s, scl_s, sda_s, asel_s, pins_s} = sync_q;
  assign int_rst = rst | ~rstn_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  gpx_pkg::gpx_state_type st_q;
  gpx_pkg::gpx_state_type st_d;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] rd_data;
  logic       load_tx;
  logic       wr_en;
  logic [7:0] changed;

  assign scl_rise  = scl_s & ~st_q.scl_prev;
  assign scl_fall  = ~scl_s & st_q.scl_prev;
  assign bus_start = scl_s & st_q.scl_prev & st_q.sda_prev & ~sda_s;
  assign bus_stop  = scl_s & st_q.scl_prev & ~st_q.sda_prev & sda_s;
  assign changed   = (pins_s ^ st_q.ref_lvl) & st_q.dir;

  always_comb begin
    if (st_q.ptr == gpx_pkg::REG_INPUT_LEVELS) begin
      rd_data = pins_s ^ st_q.invert;
    end else if (st_q.ptr == gpx_pkg::REG_OUTPUT_LATCH) begin
      rd_data = st_q.latch;
    end else if (st_q.ptr == gpx_pkg::REG_POLARITY_INVERT) begin
      rd_data = st_q.invert;
    end else if (st_q.ptr == gpx_pkg::REG_PIN_DIRECTION) begin
      rd_data = st_q.dir;
    end else begin
      rd_data = gpx_pkg::UNMAPPED_READ;
    end
  end

  always_comb begin
    st_d            = st_q;
    load_tx         = 1'b0;
    wr_en           = 1'b0;
    st_d.scl_prev   = scl_s;
    st_d.sda_prev   = sda_s;
    if (bus_start) begin
      st_d.fsm        = gpx_pkg::ST_ADDR;
      st_d.bit_cnt    = 4'h0;
      st_d.sda_oe     = 1'b0;
      st_d.first_byte = 1'b1;
    end else if (bus_stop) begin
      st_d.fsm    = gpx_pkg::ST_IDLE;
      st_d.sda_oe = 1'b0;
    end else begin
      case (st_q.fsm)
        gpx_pkg::ST_ADDR: begin
          if (scl_rise) begin
            st_d.shreg   = {st_q.shreg[6:0], sda_s};
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          end else if (scl_fall && st_q.bit_cnt == gpx_pkg::BITS_PER_BYTE) begin
            // Select pins form low address bits
            if (st_q.shreg[7:1] == {gpx_pkg::ADDR_FIXED_HIGH, asel_s}) begin
              st_d.rw         = st_q.shreg[0];
              st_d.addr_phase = 1'b1;
              st_d.sda_oe     = 1'b1;
              st_d.fsm        = gpx_pkg::ST_ACK;
            end else begin
              st_d.fsm = gpx_pkg::ST_IDLE;
            end
          end
        end
        gpx_pkg::ST_ACK: begin
          if (scl_fall) begin
            st_d.sda_oe     = 1'b0;
            st_d.bit_cnt    = 4'h0;
            st_d.addr_phase = 1'b0;
            if (st_q.addr_phase && st_q.rw) begin
              load_tx = 1'b1;
            end else begin
              st_d.fsm = gpx_pkg::ST_RX;
            end
          end
        end
        gpx_pkg::ST_RX: begin
          if (scl_rise) begin
            st_d.shreg   = {st_q.shreg[6:0], sda_s};
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          end else if (scl_fall && st_q.bit_cnt == gpx_pkg::BITS_PER_BYTE) begin
            if (st_q.first_byte) begin
              st_d.ptr        = st_q.shreg;
              st_d.first_byte = 1'b0;
            end else begin
              wr_en = 1'b1;
            end
            st_d.sda_oe = 1'b1;
            st_d.fsm    = gpx_pkg::ST_ACK;
          end
        end
        gpx_pkg::ST_TX: begin
          if (scl_fall) begin
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
            if (st_q.bit_cnt == gpx_pkg::LAST_TX_BIT) begin
              st_d.sda_oe = 1'b0;
              st_d.fsm    = gpx_pkg::ST_MACK;
            end else begin
              st_d.shreg  = {st_q.shreg[6:0], 1'b0};
              st_d.sda_oe = ~st_q.shreg[6];
            end
          end
        end
        gpx_pkg::ST_MACK: begin
          if (scl_rise) begin
            st_d.mnack = sda_s;
          end else if (scl_fall) begin
            if (!st_q.mnack) begin
              load_tx = 1'b1;
            end else begin
              st_d.fsm = gpx_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          st_d.fsm = gpx_pkg::ST_IDLE;
        end
      endcase
    end

    // Read data is taken when the byte starts, so a pin change mid-byte cannot tear it
    if (load_tx) begin
      st_d.shreg   = rd_data;
      st_d.sda_oe  = ~rd_data[7];
      st_d.bit_cnt = 4'h0;
      st_d.fsm     = gpx_pkg::ST_TX;
      if (st_q.ptr == gpx_pkg::REG_INPUT_LEVELS) begin
        st_d.ref_lvl = pins_s;
      end
    end

    if (wr_en) begin
      if (st_q.ptr == gpx_pkg::REG_OUTPUT_LATCH) begin
        st_d.latch = st_q.shreg;
      end else if (st_q.ptr == gpx_pkg::REG_POLARITY_INVERT) begin
        st_d.invert = st_q.shreg;
      end else if (st_q.ptr == gpx_pkg::REG_PIN_DIRECTION) begin
        st_d.dir = st_q.shreg;
      end
    end

    // Reference seeded from the pins once after reset, so reset raises no interrupt
    if (!st_q.ref_ok) begin
      st_d.ref_lvl = pins_s;
      st_d.ref_ok  = 1'b1;
    end

    st_d.pins_oe  = ~st_q.dir;
    st_d.pins_out = st_q.latch;
    st_d.int_oe   = st_q.ref_ok & (|changed);
    st_d.drv_low  = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      st_q <= gpx_pkg::STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sda_out       = st_q.drv_low;
  assign sda_oe        = st_q.sda_oe;
  assign port_pins_out = st_q.pins_out;
  assign port_pins_oe  = st_q.pins_oe;
  assign int_n_out     = st_q.drv_low;
  assign int_n_oe      = st_q.int_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence cmd_byte_done_s;
    st_q.fsm == gpx_pkg::ST_RX && st_q.first_byte && scl_fall && st_q.bit_cnt == gpx_pkg::BITS_PER_BYTE
      && !int_rst;
  endsequence

  sequence reset_held_s;
    int_rst ##1 !int_rst;
  endsequence

  reset_defaults_a: assert property (reset_held_s |-> st_q.dir == 8'hff && st_q.latch == 8'hff
    && st_q.invert == 8'h00 && port_pins_oe == 8'h00)
    else $error("registers not at defaults after reset");

  dir_enable_a: assert property (!$past(int_rst) |-> port_pins_oe == ~$past(st_q.dir))
    else $error("pin enable does not follow direction");

  latch_level_a: assert property (!$past(int_rst) |-> port_pins_out == $past(st_q.latch))
    else $error("pin level does not follow latch");

  ptr_hold_a: assert property (!$past(int_rst) && $changed(st_q.ptr) |-> $past(st_q.fsm == gpx_pkg::ST_RX)
    && $past(st_q.first_byte))
    else $error("pointer changed outside command byte");

  cmd_pointer_a: assert property (cmd_byte_done_s |=> st_q.ptr == $past(st_q.shreg))
    else $error("command byte not stored as pointer");

  ro_write_a: assert property (wr_en && st_q.ptr == gpx_pkg::REG_INPUT_LEVELS && !int_rst
    |=> $stable(st_q.latch) && $stable(st_q.invert) && $stable(st_q.dir))
    else $error("write to input register changed state");

  int_raise_a: assert property (st_q.ref_ok && (|changed) && !int_rst |=> int_n_oe && !int_n_out)
    else $error("interrupt not raised on input change");

  read_snap_a: assert property (load_tx && st_q.ptr == gpx_pkg::REG_INPUT_LEVELS && !int_rst
    |=> st_q.ref_lvl == $past(pins_s) ##1 (int_n_oe == (|((($past(pins_s, 1)) ^ st_q.ref_lvl) & $past(st_q.dir))) || $past(int_rst)))
    else $error("input read did not capture reference");

  read_data_a: assert property (load_tx && !int_rst |=> st_q.shreg ==
    ($past(st_q.ptr) == gpx_pkg::REG_OUTPUT_LATCH    ? $past(st_q.latch) :
     $past(st_q.ptr) == gpx_pkg::REG_INPUT_LEVELS    ? ($past(pins_s) ^ $past(st_q.invert)) :
     $past(st_q.ptr) == gpx_pkg::REG_POLARITY_INVERT ? $past(st_q.invert) :
     $past(st_q.ptr) == gpx_pkg::REG_PIN_DIRECTION   ? $past(st_q.dir) : gpx_pkg::UNMAPPED_READ))
    else $error("wrong read data loaded");

endmodule

//--- testbench/gpx_host_model.sv
// Two-wire bus host model that drives the expander's target side
`timescale 1ns/1ps
module gpx_host_model (
  input  wire logic       sys_clk,
  input  wire logic       sda_line,
  input  wire logic [6:0] dev_addr,
  output logic            scl,
  output logic            sda_low,
  output logic            rd_stb,
  output logic [7:0]      rd_byte,
  output logic            addr_ack
);
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
    addr_ack = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Data moves only while scl is low, after a short hold
  task automatic bit_io(input logic b, output logic got);
    wt(2);
    sda_low = ~b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF / 2);
    got = sda_line;
    wt(HALF / 2);
    scl = 1'b0;
  endtask

  // Also serves as repeated start from a low clock
  task automatic start_c;
    wt(2);
    sda_low = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask

  task automatic stop_c;
    wt(2);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic g9);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], g);
      rx[i] = g;
    end
    bit_io(b9, g9);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input int n);
    logic [7:0] rx;
    logic       g;
    start_c();
    byte_io({dev_addr, 1'b0}, 1'b1, rx, g);
    addr_ack = ~g;
    byte_io(ptr, 1'b1, rx, g);
    if (n > 0) byte_io(d0, 1'b1, rx, g);
    if (n > 1) byte_io(d1, 1'b1, rx, g);
    stop_c();
  endtask

  // Last byte is refused so the target lets go of the line
  task automatic rd(input int n);
    logic [7:0] rx;
    logic       g;
    start_c();
    byte_io({dev_addr, 1'b1}, 1'b1, rx, g);
    addr_ack = ~g;
    for (int k = 0; k < n; k++) begin
      byte_io(8'hff, k == n - 1, rx, g);
      rd_byte = rx;
      rd_stb = 1'b1;
      wt(1);
      rd_stb = 1'b0;
    end
    stop_c();
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the eight-bit I/O expander
`timescale 1ns/1ps
module testbench;
  logic       sys_clk, rst, reset_pin_n, a0, a1;
  logic [7:0] ext, lat, dir, inv;
  logic [6:0] dev_addr;
  logic       sda_out, sda_oe, scl, sda_low, rd_stb, addr_ack, int_n_out, int_n_oe;
  logic [7:0] pins_out, pins_oe, rd_byte;
  int         fails, n_tests, cyc;
  logic [7:0] exp_q[$];
  wire  logic       sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
  wire  logic [7:0] pins_in  = (pins_oe & pins_out) | (~pins_oe & ext);

  gpx_expander dut (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin0(a0), .addr_select_pin1(a1),
    .port_pins_in(pins_in), .port_pins_out(pins_out), .port_pins_oe(pins_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  gpx_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .dev_addr(dev_addr), .scl(scl),
    .sda_low(sda_low), .rd_stb(rd_stb), .rd_byte(rd_byte), .addr_ack(addr_ack));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Sets the pointer, then reads n bytes that should all match
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp, input int n);
    host.wr(ptr, 8'h00, 8'h00, 0);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(exp);
    end
    host.rd(n);
  endtask

  task automatic int_chk(input logic exp);
    host.wt(6);
    chk("interrupt", {7'h00, exp}, {7'h00, int_n_oe});
    chk("interrupt level", 8'h00, {7'h00, int_n_out});
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Oldest expectation is matched to each byte the host receives
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("CHECK FAILED read byte expected none seen %h", rd_byte);
      end else begin
        chk("read byte", exp_q.pop_front(), rd_byte);
      end
    end
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    ext = 8'h00;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h2b59));
    {a1, a0} = 2'($urandom);
    dev_addr = {gpx_pkg::ADDR_FIXED_HIGH, a1, a0};
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    host.wt(6);
    chk("pin enables", 8'h00, pins_oe);
    rd_chk(8'h01, 8'hff, 2);
    chk("address ack", 8'h01, {7'h00, addr_ack});
    rd_chk(8'h02, 8'h00, 1);
    rd_chk(8'h03, 8'hff, 1);
    for (int k = 0; k < 3; k++) begin
      lat = 8'($urandom);
      dir = 8'($urandom);
      inv = 8'($urandom);
      ext = 8'($urandom);
      host.wr(8'h01, ~lat, lat, 2);
      host.wr(8'h02, inv, 8'h00, 1);
      host.wr(8'h03, dir, 8'h00, 1);
      host.wr(8'h00, ~lat, 8'h00, 1);
      host.wt(4);
      chk("pin enables", ~dir, pins_oe);
      chk("pin levels", lat & ~dir, pins_out & ~dir);
      rd_chk(8'h01, lat, 1);
      rd_chk(8'h02, inv, 1);
      rd_chk(8'h03, dir, 1);
      rd_chk(8'h00, ((lat & ~dir) | (ext & dir)) ^ inv, 2);
      rd_chk(8'($urandom) | 8'h04, gpx_pkg::UNMAPPED_READ, 1);
    end
    host.wr(8'h03, 8'hff, 8'h00, 1);
    ext = 8'h00;
    rd_chk(8'h00, inv, 1);
    int_chk(1'b0);
    ext[3] = 1'b1;
    int_chk(1'b1);
    ext[3] = 1'b0;
    int_chk(1'b0);
    ext[5] = 1'b1;
    int_chk(1'b1);
    rd_chk(8'h00, 8'h20 ^ inv, 1);
    int_chk(1'b0);
    host.wr(8'h01, 8'h01, 8'h00, 1);
    host.wr(8'h03, 8'hfe, 8'h00, 1);
    ext[0] = 1'b1;
    int_chk(1'b0);
    host.wr(8'h03, 8'hff, 8'h00, 1);
    int_chk(1'b1);
    dev_addr = dev_addr ^ (7'h01 << ($urandom % 7));
    host.wr(8'h01, 8'h00, 8'h00, 1);
    chk("address ack", 8'h00, {7'h00, addr_ack});
    dev_addr = {gpx_pkg::ADDR_FIXED_HIGH, a1, a0};
    rd_chk(8'h01, 8'h01, 1);
    host.wr(8'h03, 8'h00, 8'h00, 1);
    reset_pin_n = 1'b0;
    host.wt(3);
    reset_pin_n = 1'b1;
    host.wt(6);
    chk("pin enables", 8'h00, pins_oe);
    int_chk(1'b0);
    rd_chk(8'h01, 8'hff, 1);
    rd_chk(8'h03, 8'hff, 1);
    {a1, a0} = {a1, a0} ^ 2'(1 + $urandom % 3);
    dev_addr = {gpx_pkg::ADDR_FIXED_HIGH, a1, a0};
    rd_chk(8'h01, 8'hff, 1);
    chk("address ack", 8'h01, {7'h00, addr_ack});
    host.wt(20);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule
